// file: verilog/ccp_pwm_ctrl.sv
// Two capture/compare/PWM channels behind an APB register slave
`timescale 1ns/1ns
module ccp_pwm_ctrl
  import ccp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] channel_pin_in,
  input wire logic [NCH-1:0] pin_change_event,
  input wire logic [15:0] sixteen_bit_timer,
  input wire logic [7:0] period_timer_count,
  input wire logic [7:0] period_limit_reg,
  input wire logic [1:0] time_base_lsb,
  input wire logic timer_step,
  input wire logic sleep_mode,
  output logic [NCH-1:0] channel_pin_out,
  output logic [NCH-1:0] channel_interrupt_flag,
  output logic [NCH-1:0] timer_clear
);

  typedef struct packed {
    ccp_ch_s [NCH-1:0] ch;
    logic [NCH-1:0] sync1;
    logic [NCH-1:0] sync2;
    logic [NCH-1:0] flag;
    logic [NCH-1:0] tclr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ccp_state_s;

  ccp_state_s st_q;
  ccp_state_s st_d;

  function automatic ccp_kind_e kind_of(input logic [3:0] m);
    ccp_kind_e k;
    k = K_CMP;
    if (m == MODE_OFF) begin
      k = K_OFF;
    end else if (m[3:2] == MODE_PWM_TOP) begin
      k = K_PWM;
    end else if (m >= MODE_CAP_ANY && m <= MODE_CAP_16) begin
      k = K_CAP;
    end
    return k;
  endfunction

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
    return {idx, 2'b00};
  endfunction

  // Pulse width as seen by the 10-bit time base
  function automatic logic [9:0] duty_of(input logic [15:0] v,
                                         input logic f);
    return f ? v[15:LEFT_LSB] : v[9:0];
  endfunction

  logic period_evt;
  logic [9:0] time_base;
  logic [NCH-1:0] src_lvl;
  logic [NCH-1:0] rise;
  logic [NCH-1:0] fall;
  logic [NCH-1:0] cmp_hit;
  logic [NCH-1:0] match;
  logic [NCH-1:0] hit_val;
  logic [NCH-1:0] hit_ctl;
  logic [NCH-1:0] hit_cap;

  assign period_evt = timer_step && (period_timer_count == period_limit_reg);
  assign time_base = {period_timer_count, time_base_lsb};

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // Reserved source codes give no edges at all
      assign src_lvl[g] = (st_q.ch[g].cts == CTS_IOC) ? pin_change_event[g]
                        : st_q.sync2[g]; // [R12]
      assign rise[g] = (st_q.ch[g].cts <= CTS_IOC) && src_lvl[g]
                       && !st_q.ch[g].src_prev;
      assign fall[g] = (st_q.ch[g].cts <= CTS_IOC) && !src_lvl[g]
                       && st_q.ch[g].src_prev;
      assign match[g] = (sixteen_bit_timer == st_q.ch[g].value); // [R21]
      // Only the first cycle of a match counts, so a stopped timer
      // does not retrigger every clock
      assign cmp_hit[g] = match[g] && !st_q.ch[g].match_prev;
      assign hit_val[g] = paddr == byte_addr(IDX_VALUE[g]);
      assign hit_ctl[g] = paddr == byte_addr(IDX_CTRL[g]);
      assign hit_cap[g] = paddr == byte_addr(IDX_CAP[g]);
      assign channel_pin_out[g] = st_q.ch[g].out;
    end
  endgenerate

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign channel_interrupt_flag = st_q.flag;
  assign timer_clear = st_q.tclr;

  always_comb begin
    logic wr;
    logic mapped;
    logic trig;
    ccp_ch_s c;
    st_d = st_q;
    wr = psel && penable && st_q.pready && pwrite;
    mapped = 1'b0;
    trig = 1'b0;
    c = st_q.ch[0];
    st_d.prdata = 32'h0000_0000;
    st_d.flag = '0;
    st_d.tclr = '0;
    st_d.sync1 = channel_pin_in;
    st_d.sync2 = st_q.sync1;
    for (int i = 0; i < NCH; i++) begin
      c = st_q.ch[i];
      // Register writes land first; channel events below override them
      if (wr && hit_val[i]) begin
        c.value = pwdata[15:0]; // [R14] [R15] [R16]
      end
      if (wr && hit_ctl[i]) begin
        c.en = pwdata[CTL_EN_BIT];
        c.fmt = pwdata[CTL_FMT_BIT];
        c.mode = pwdata[3:0];
      end
      if (wr && hit_cap[i]) begin
        c.cts = pwdata[1:0];
      end
      if (!sleep_mode) begin
        c.src_prev = src_lvl[i];
        c.match_prev = match[i];
        if (!st_q.ch[i].en || st_q.ch[i].mode == MODE_OFF) begin
          c.out = 1'b0; // [R01] [R04] [R07]
          c.pre_cnt = 4'h0;
        end else begin
          case (kind_of(st_q.ch[i].mode))
            K_CAP: begin
              c.out = 1'b0;
              trig = 1'b0;
              case (st_q.ch[i].mode)
                MODE_CAP_ANY: trig = rise[i] || fall[i]; // [R11]
                MODE_CAP_FALL: trig = fall[i]; // [R10]
                MODE_CAP_RISE: trig = rise[i]; // [R10]
                MODE_CAP_4: begin
                  if (rise[i]) begin
                    trig = st_q.ch[i].pre_cnt >= PRE4_LAST; // [R10]
                    c.pre_cnt = trig ? 4'h0
                              : 4'(st_q.ch[i].pre_cnt + 4'h1);
                  end
                end
                MODE_CAP_16: begin
                  if (rise[i]) begin
                    trig = st_q.ch[i].pre_cnt == PRE16_LAST; // [R10]
                    c.pre_cnt = 4'(st_q.ch[i].pre_cnt + 4'h1);
                  end
                end
                default: trig = 1'b0;
              endcase
              if (trig) begin
                c.value = sixteen_bit_timer; // [R21]
                st_d.flag[i] = 1'b1; // [R04]
              end
            end
            K_CMP: begin
              c.pre_cnt = 4'h0;
              if (cmp_hit[i]) begin
                st_d.flag[i] = 1'b1; // [R04]
                case (st_q.ch[i].mode)
                  MODE_SET: c.out = 1'b1; // [R07]
                  MODE_CLR: c.out = 1'b0; // [R07]
                  MODE_PULSE: c.out = 1'b1; // [R06]
                  MODE_PULSE_CLR: begin
                    c.out = 1'b1; // [R06]
                    st_d.tclr[i] = 1'b1; // [R09]
                  end
                  MODE_TGL: c.out = !st_q.ch[i].out; // [R08]
                  MODE_TGL_CLR: begin
                    c.out = !st_q.ch[i].out; // [R08]
                    st_d.tclr[i] = 1'b1; // [R09]
                  end
                  default: c.out = st_q.ch[i].out;
                endcase
              end else if (st_q.ch[i].mode == MODE_PULSE
                           || st_q.ch[i].mode == MODE_PULSE_CLR) begin
                c.out = 1'b0; // [R06]
              end
            end
            K_PWM: begin
              c.pre_cnt = 4'h0;
              if (period_evt) begin
                // Buffered width only changes at the wrap: no glitches
                c.duty_buf = duty_of(st_q.ch[i].value,
                                     st_q.ch[i].fmt); // [R03] [R05] [R18]
                c.out = c.duty_buf != 10'h000; // [R18]
                st_d.flag[i] = 1'b1; // [R04]
              end else if (time_base == st_q.ch[i].duty_buf) begin
                c.out = 1'b0; // [R19]
              end
            end
            default: c.out = 1'b0;
          endcase
        end
      end
      // Sleep freezes the channel's event logic and output; register writes still land [R20]
      st_d.ch[i] = c; // [R17]
      if (hit_val[i] || hit_ctl[i] || hit_cap[i]) begin
        mapped = 1'b1;
      end
    end
    // Read data is latched in the setup cycle, one cycle before use
    if (psel && !penable) begin
      for (int i = 0; i < NCH; i++) begin
        if (hit_val[i]) begin
          st_d.prdata = {16'h0000, st_q.ch[i].value};
        end
        if (hit_ctl[i]) begin
          st_d.prdata = {24'h00_0000, st_q.ch[i].en, 1'b0,
                         st_q.ch[i].out, st_q.ch[i].fmt,
                         st_q.ch[i].mode}; // [R02]
        end
        if (hit_cap[i]) begin
          st_d.prdata = {30'h0000_0000, st_q.ch[i].cts};
        end
      end
    end
    st_d.pready = psel && !penable;
    st_d.pslverr = psel && !penable && !mapped;
  end

  // Reset here stands for power-on: the value register starts at zero,
  // which is one legal choice for its undefined content
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0; // [R13]
    end else begin
      st_q <= st_d;
    end
  end

  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_enable_off_low: assert property ( // [R01]
    (!st_q.ch[0].en && !sleep_mode) |=> !channel_pin_out[0])
    else $error("disabled channel drives output high");

  a_out_bit_read: assert property ( // [R02]
    (psel && !penable && !pwrite && hit_ctl[0])
    |=> (prdata[CTL_OUT_BIT] == $past(channel_pin_out[0])))
    else $error("output bit readback wrong");

  a_left_align_buf: assert property ( // [R03]
    (period_evt && !sleep_mode && st_q.ch[0].en && st_q.ch[0].fmt
     && kind_of(st_q.ch[0].mode) == K_PWM)
    |=> st_q.ch[0].duty_buf == $past(st_q.ch[0].value[15:6]))
    else $error("left aligned width not buffered");

  a_right_align_buf: assert property ( // [R15]
    (period_evt && !sleep_mode && st_q.ch[1].en && !st_q.ch[1].fmt
     && kind_of(st_q.ch[1].mode) == K_PWM)
    |=> st_q.ch[1].duty_buf == $past(st_q.ch[1].value[9:0]))
    else $error("right aligned width not buffered");

  a_off_no_flag: assert property ( // [R04]
    (st_q.ch[0].mode == MODE_OFF) |=> !channel_interrupt_flag[0])
    else $error("flag raised in disabled mode");

  a_pwm_no_clear: assert property ( // [R05]
    (st_q.ch[0].mode[3:2] == MODE_PWM_TOP) |=> !timer_clear[0])
    else $error("timer cleared in PWM mode");

  a_pulse_one_cycle: assert property ( // [R06]
    (st_q.ch[0].en && st_q.ch[0].mode == MODE_PULSE
     && channel_pin_out[0] && !sleep_mode) |=> !channel_pin_out[0])
    else $error("compare pulse longer than one cycle");

  a_set_on_match: assert property ( // [R07]
    (st_q.ch[0].en && st_q.ch[0].mode == MODE_SET && cmp_hit[0]
     && !sleep_mode) |=> channel_pin_out[0] ##1 channel_pin_out[0])
    else $error("set mode did not hold output high");

  a_toggle_match: assert property ( // [R08]
    (st_q.ch[0].en && st_q.ch[0].mode == MODE_TGL && cmp_hit[0]
     && !sleep_mode) |=> channel_pin_out[0] != $past(channel_pin_out[0]))
    else $error("toggle mode did not toggle");

  a_clear_cause: assert property ( // [R09]
    timer_clear[0] |-> ($past(st_q.ch[0].mode) == MODE_TGL_CLR
                        || $past(st_q.ch[0].mode) == MODE_PULSE_CLR))
    else $error("timer clear from wrong mode");

  a_capture_copy: assert property ( // [R21]
    (channel_interrupt_flag[0] && $past(kind_of(st_q.ch[0].mode)) == K_CAP)
    |-> st_q.ch[0].value == $past(sixteen_bit_timer))
    else $error("capture did not copy timer");

  a_pwm_set_wrap: assert property ( // [R18]
    (period_evt && !sleep_mode && st_q.ch[0].en
     && kind_of(st_q.ch[0].mode) == K_PWM)
    |=> channel_pin_out[0] == (st_q.ch[0].duty_buf != 10'h000))
    else $error("PWM output wrong after wrap");

  a_sleep_hold: assert property ( // [R20]
    sleep_mode |=> $stable(channel_pin_out))
    else $error("output changed during sleep");

endmodule

// file: verilog/ccp_pkg.sv
// Constants and types for the capture/compare/PWM channel block
//
// Contract
// R01: Control bit 7 enables the channel when 1, disables it when 0.
// R02: Control bit 5 is read-only and shows the channel output level.
// R03: In PWM, bit 4 selects left (1) or right (0) alignment; else ignored.
// R04: Mode 0000 disables; every other mode raises the flag on its event.
// R05: Any mode 11xx puts the channel into PWM operation.
// R06: Mode 1010 pulses the output on match; 1011 also clears the timer.
// R07: Mode 1000 sets, 1001 clears output; undone by mode 0000 or disable.
// R08: Mode 0010 toggles output on match; 0001 also clears the timer.
// R09: Modes 0001 and 1011 clear the associated 16-bit timer on match.
// R10: Capture 0100 falling, 0101 rising, 0110 4th rising, 0111 16th rising.
// R11: Capture 0011 triggers on every edge of the capture input.
// R12: Source select 00 routed pin, 01 pin-change event, 10/11 reserved.
// R13: Value register undefined at power-on, kept through other resets.
// R14: In capture/compare the value is a high byte and a low byte.
// R15: PWM right-aligned: width in bits 9:0, bits 15:10 unused.
// R16: PWM left-aligned: width in bits 15:6, bits 5:0 unused.
// R17: Two identical channels, each with its own three registers.
// R18: Period wrap clears timer, sets output unless duty zero, loads buffer.
// R19: Output clears when the 10-bit time base equals the buffered width.
// R20: In sleep the channel state freezes and the output holds its level.
// R21: Capture copies the 16-bit timer; compare matches timer to value.
package ccp_pkg;

  localparam int NCH = 2;
  localparam int ADDR_W = 14;

  // Printed offsets are register indices; byte address is index times four
  localparam logic [11:0] IDX_VALUE [0:NCH-1] = '{12'h30C, 12'h310};
  localparam logic [11:0] IDX_CTRL [0:NCH-1] = '{12'h30E, 12'h312};
  localparam logic [11:0] IDX_CAP [0:NCH-1] = '{12'h30F, 12'h313};

  localparam int CTL_EN_BIT = 7;
  localparam int CTL_OUT_BIT = 5;
  localparam int CTL_FMT_BIT = 4;
  localparam int LEFT_LSB = 6;

  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TGL_CLR = 4'h1;
  localparam logic [3:0] MODE_TGL = 4'h2;
  localparam logic [3:0] MODE_CAP_ANY = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4 = 4'h6;
  localparam logic [3:0] MODE_CAP_16 = 4'h7;
  localparam logic [3:0] MODE_SET = 4'h8;
  localparam logic [3:0] MODE_CLR = 4'h9;
  localparam logic [3:0] MODE_PULSE = 4'hA;
  localparam logic [3:0] MODE_PULSE_CLR = 4'hB;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;

  localparam logic [1:0] CTS_PIN = 2'h0;
  localparam logic [1:0] CTS_IOC = 2'h1;

  localparam logic [3:0] PRE4_LAST = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hF;

  typedef enum {K_OFF, K_CAP, K_CMP, K_PWM} ccp_kind_e;

  typedef struct packed {
    logic en;
    logic fmt;
    logic [3:0] mode;
    logic [1:0] cts;
    logic [15:0] value;
    logic out;
    logic [9:0] duty_buf;
    logic [3:0] pre_cnt;
    logic src_prev;
    logic match_prev;
  } ccp_ch_s;

endpackage

// file: verification/ccp_far_side.sv
// Far-side model: shared 16-bit timer and the period timer
`timescale 1ns/1ns
module ccp_far_side #(
  parameter logic [7:0] LIMIT = 8'h07
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic [1:0] timer_clear,
  input wire logic sleep_mode,
  output logic [15:0] sixteen_bit_timer,
  output logic [7:0] period_timer_count,
  output logic [7:0] period_limit_reg,
  output logic [1:0] time_base_lsb,
  output logic timer_step
);
  assign period_limit_reg = LIMIT;
  // Steps only on the last prescaler phase, never while asleep
  assign timer_step = (time_base_lsb == 2'h3) && !sleep_mode;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sixteen_bit_timer <= 16'h0000;
      period_timer_count <= 8'h00;
      time_base_lsb <= 2'h0;
    end else begin
      if (load) sixteen_bit_timer <= load_val;
      else if (|timer_clear) sixteen_bit_timer <= 16'h0000;
      else if (run) sixteen_bit_timer <= sixteen_bit_timer + 16'h0001;
      if (!sleep_mode) time_base_lsb <= time_base_lsb + 2'h1;
      if (timer_step && period_timer_count == LIMIT) begin
        period_timer_count <= 8'h00;
      end else if (timer_step) begin
        period_timer_count <= period_timer_count + 8'h01;
      end
    end
  end
endmodule

// file: verification/ccp_pwm_ctrl_tb_top.sv
// Self-checking bench for the capture/compare/PWM channel block
`timescale 1ns/1ns
module ccp_pwm_ctrl_tb_top;
  import ccp_pkg::*;
  localparam int P = 32;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, run = 1'b1, load = 1'b0, sleep_mode = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, timer_step, e;
  logic [NCH-1:0] channel_pin_in = '0, pin_change_event = '0;
  logic [NCH-1:0] pout, flag, timer_clear;
  logic [15:0] sixteen_bit_timer, ld_val = '0;
  logic [7:0] period_timer_count, period_limit_reg;
  logic [1:0] time_base_lsb;
  int error_cnt = 0, total_checks = 0, cyc = 0, seed = 36;
  int flg [NCH];
  always #4 pclk = ~pclk;
  ccp_pwm_ctrl u_ccp_pwm_ctrl (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .channel_pin_in,
    .pin_change_event, .sixteen_bit_timer, .period_timer_count,
    .period_limit_reg, .time_base_lsb, .timer_step, .sleep_mode,
    .channel_pin_out(pout), .channel_interrupt_flag(flag), .timer_clear);
  ccp_far_side #(.LIMIT(8'h07)) u_ccp_far_side (.pclk, .presetn, .run,
    .load, .load_val(ld_val), .timer_clear, .sleep_mode, .sixteen_bit_timer,
    .period_timer_count, .period_limit_reg, .time_base_lsb, .timer_step);
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    for (int c = 0; c < NCH; c++) if (flag[c] === 1'b1) flg[c] <= flg[c] + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic chk1(string nm, logic ex, logic got);
    total_checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", nm, ex, got);
    end
  endtask
  // APB master: holds the request until pready is seen at an edge
  task automatic apb(logic wr, logic [ADDR_W-1:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so the next call never re-drives psel in this step
    @(posedge pclk);
  endtask
  function automatic logic [ADDR_W-1:0] ad(int c, int k);
    logic [11:0] i;
    i = (k == 0) ? IDX_VALUE[c] : (k == 1) ? IDX_CTRL[c] : IDX_CAP[c];
    return {i, 2'b00};
  endfunction
  task automatic rdchk(string nm, logic [ADDR_W-1:0] a, logic [31:0] ex);
    apb(1'b0, a, '0);
    chk(nm, ex, q);
  endtask
  task automatic wflag(int c);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (flag[c] !== 1'b1 && n < 200);
  endtask
  task automatic edges(int c, logic viaioc);
    repeat (16) begin
      if (viaioc) pin_change_event[c] <= 1'b1;
      else channel_pin_in[c] <= 1'b1;
      repeat (6) @(posedge pclk);
      pin_change_event[c] <= 1'b0;
      channel_pin_in[c] <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  endtask
  function automatic int hexp(int d);
    return (d == 0) ? 0 : (d + 1 > P) ? P : d + 1;
  endfunction
  initial begin
    logic [15:0] v;
    logic [31:0] d;
    logic b;
    int n, h, c;
    logic [3:0] cm [7] = '{4'h8, 4'h9, 4'h8, 4'h2, 4'h1, 4'hA, 4'hB};
    logic [6:0] exo = 7'b1111101, clr = 7'b1010000;
    logic [6:0] pul = 7'b1100000, pre = 7'b0101000;
    logic [3:0] cp [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h0, 4'h5,
      4'h5, 4'h5};
    logic [1:0] cs [9] = '{0, 0, 0, 0, 0, 0, 0, 1, 2};
    int cx [9] = '{32, 16, 16, 4, 1, 0, 0, 16, 0};
    logic [8:0] ce = 9'b110111111;
    logic [9:0] pd [5] = '{10'd0, 10'd5, 10'd20, 10'd12, 10'd40};
    logic [4:0] pa = 5'b10100;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (c = 0; c < NCH; c++) begin
      rdchk("ctrl reset", ad(c, 1), 32'h0);
      rdchk("value reset", ad(c, 0), 32'h0);
      v = $random(seed);
      apb(1'b1, ad(c, 0), {16'hFFFF, v});
      rdchk("value rw", ad(c, 0), {16'h0, v});
      d = $random(seed);
      apb(1'b1, ad(c, 2), d);
      rdchk("select rw", ad(c, 2), {30'h0, d[1:0]});
      apb(1'b1, ad(c, 1), {24'h0, 3'h3, d[4:0]});
      rdchk("ctrl ro bits", ad(c, 1), {24'h0, 3'h0, d[4:0]});
      apb(1'b1, ad(c, 1), 32'hE0);
      rdchk("ctrl enable", ad(c, 1), 32'h80);
      apb(1'b1, ad(c, 1), 32'h0);
    end
    apb(1'b0, 14'h0004, '0);
    chk1("unmapped err", 1'b1, e);
    chk("unmapped data", 32'h0, q);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      c = (i > 3);
      if (pre[i]) begin
        apb(1'b1, ad(c, 1), 32'h0);
        repeat (2) @(posedge pclk);
        chk1("off out", 1'b0, pout[c]);
      end
      v = $random(seed);
      apb(1'b1, ad(c, 0), {16'h0, v});
      apb(1'b1, ad(c, 1), {24'h0, 4'h8, cm[i]});
      ld_val <= v - 16'h0008;
      load <= 1'b1;
      @(posedge pclk);
      load <= 1'b0;
      wflag(c);
      chk1("cmp flag", 1'b1, flag[c]);
      chk1("cmp out", exo[i], pout[c]);
      chk1("timer clear", clr[i], timer_clear[c]);
      @(posedge pclk);
      if (pul[i]) chk1("pulse end", 1'b0, pout[c]);
      if (i == 0) rdchk("ctrl out bit", ad(0, 1), 32'hA8);
    end
    apb(1'b1, ad(1, 1), 32'h0);
    $display("test compare done");
    run <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      c = i % 2;
      v = $random(seed);
      ld_val <= v;
      load <= 1'b1;
      apb(1'b1, ad(c, 2), {30'h0, cs[i]});
      apb(1'b1, ad(c, 1), {24'h0, ce[i], 3'h0, cp[i]});
      load <= 1'b0;
      n = flg[c];
      edges(c, cs[i] == 2'h1);
      chk("capture count", cx[i], flg[c] - n);
      if (cx[i] != 0) rdchk("capture value", ad(c, 0), {16'h0, v});
      apb(1'b1, ad(c, 1), 32'h0);
    end
    run <= 1'b1;
    $display("test capture done");
    for (int i = 0; i < 5; i++) begin
      c = i % 2;
      d = $random(seed);
      v = pa[i] ? {pd[i], d[5:0]} : {d[5:0], pd[i]};
      apb(1'b1, ad(c, 0), {16'h0, v});
      apb(1'b1, ad(c, 1), {24'h0, 3'h4, pa[i], 2'h3, d[7:6]});
      wflag(c);
      wflag(c);
      h = (pout[c] === 1'b1);
      repeat (P - 1) begin
        @(posedge pclk);
        h += (pout[c] === 1'b1);
      end
      chk("pwm high", hexp(pd[i]), h);
      if (i == 2) begin
        wflag(c);
        sleep_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        b = pout[c];
        n = flg[c];
        repeat (100) @(posedge pclk);
        chk1("sleep out", b, pout[c]);
        chk("sleep flags", n, flg[c]);
        sleep_mode <= 1'b0;
      end
      apb(1'b1, ad(c, 1), 32'h0);
    end
    $display("test pwm done");
    report_and_stop();
  end
endmodule
